// ---- pkg/bgdio_pkg.sv ----
`default_nettype none
package bgdio_pkg;

    localparam int GROUP_W  = 8;
    localparam int GROUPS   = 2;
    localparam int LINES    = GROUP_W * GROUPS;

    // Split codes as software writes them.
    localparam logic [1:0] SPLIT_ALL_IN  = 2'h0;
    localparam logic [1:0] SPLIT_HALF    = 2'h1;
    localparam logic [1:0] SPLIT_ALL_OUT = 2'h2;
    localparam logic [1:0] SPLIT_BAD     = 2'h3;

    // Group directions: bit 0 for lines 7:0, bit 1 for lines 15:8, 1 meaning output.
    localparam logic [GROUPS-1:0] DIR_ALL_IN  = 2'h0;
    localparam logic [GROUPS-1:0] DIR_HALF    = 2'h2;
    localparam logic [GROUPS-1:0] DIR_ALL_OUT = 2'h3;

    // Jumper level: 0 is position 1-2, 1 is position 2-3.
    localparam logic JUMPER_SOFT  = 1'b0;
    localparam logic JUMPER_FIXED = 1'b1;

    // In the fixed split, the top line of the output group carries the hold strobe.
    localparam int HOLD_BIT = GROUP_W - 1;

    localparam logic [GROUPS-1:0] DIR_RESET  = 2'h0;
    localparam logic [GROUPS-1:0] DIR_FIXED  = 2'h2;
    localparam logic [LINES-1:0]  DATA_RESET = 16'h0000;

    typedef enum logic [1:0] {
        BGDIO_SOFT,
        BGDIO_FIXED
    } bgdio_mode_t;

endpackage : bgdio_pkg
`default_nettype wire

// ---- pkg/bgdio_dir_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface bgdio_dir_if;
    logic [1:0] split;
    logic       fixed;
    logic [1:0] grp_out;

    modport ctrl (output split, output fixed, input grp_out);
    modport dec  (input split, input fixed, output grp_out);
endinterface : bgdio_dir_if
`default_nettype wire

// ---- src/bgdio_dir_dec.sv ----
`timescale 1ns/100ps
`default_nettype none
module bgdio_dir_dec (
    bgdio_dir_if.dec d
);
    // The group-level granularity is decided here, never per line.
    always_comb begin
        if (d.fixed) begin
            d.grp_out = bgdio_pkg::DIR_FIXED;
        end else begin
            case (d.split)
                bgdio_pkg::SPLIT_HALF:    d.grp_out = bgdio_pkg::DIR_HALF;
                bgdio_pkg::SPLIT_ALL_OUT: d.grp_out = bgdio_pkg::DIR_ALL_OUT;
                default:                  d.grp_out = bgdio_pkg::DIR_ALL_IN;
            endcase
        end
    end
endmodule : bgdio_dir_dec
`default_nettype wire

// ---- src/bgdio_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module bgdio_port (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        direction_mode_jumper,
    input  wire logic        cfg_wr,
    input  wire logic [1:0]  cfg_split,
    input  wire logic        data_wr,
    input  wire logic [15:0] data_wdata,
    input  wire logic        hold_strobe,
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe,
    output logic      [15:0] data_rdata,
    output logic      [1:0]  dir_out
);
    logic [1:0]  split;
    logic [1:0]  next_split;
    logic [15:0] out_latch;
    logic [15:0] next_out_latch;
    logic [15:0] next_pin_out;
    logic [15:0] next_pin_oe;
    logic [15:0] next_rdata;
    logic [1:0]  next_dir_out;
    logic [1:0]  grp_out;
    logic        fixed_mode;

    bgdio_dir_if dif ();

    assign fixed_mode = (direction_mode_jumper == bgdio_pkg::JUMPER_FIXED);
    assign dif.split  = split;
    assign dif.fixed  = fixed_mode;
    assign grp_out    = dif.grp_out;

    bgdio_dir_dec u_dec (
        .d (dif.dec)
    );

    // One enable per line, copied from the direction bit of its group.
    function automatic logic [15:0] expand(input logic [1:0] g);
        expand = {{bgdio_pkg::GROUP_W{g[1]}}, {bgdio_pkg::GROUP_W{g[0]}}};
    endfunction : expand

    function automatic logic split_legal(input logic [1:0] code);
        split_legal = (code != bgdio_pkg::SPLIT_BAD);
    endfunction : split_legal

    // Output groups return the latch rather than the pin, so a line held down by a
    // short still reads back what software asked for.
    function automatic logic [15:0] read_back(input logic [15:0] pins,
                                              input logic [15:0] latch,
                                              input logic [1:0]  g);
        read_back = (pins & ~expand(g)) | (latch & expand(g));
    endfunction : read_back

    function automatic logic [15:0] drive_value(input logic [15:0] latch,
                                                input logic [1:0]  g,
                                                input logic        fixed_sel,
                                                input logic        strobe);
        drive_value = latch & expand(g);
        if (fixed_sel) begin
            drive_value[bgdio_pkg::GROUP_W + bgdio_pkg::HOLD_BIT] = strobe;
        end
    endfunction : drive_value

    // A refused code leaves the old split in place, so the groups never take a
    // direction pattern that the decoder does not know.
    always_comb begin
        next_split = split;
        if (cfg_wr && split_legal(cfg_split)) begin
            next_split = cfg_split;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            split <= bgdio_pkg::SPLIT_ALL_IN;
        end else begin
            split <= next_split;
        end
    end

    // The latch is kept whole for input groups too: a later switch to output then
    // shows the last written value instead of a stale one.
    always_comb begin
        next_out_latch = out_latch;
        if (data_wr) begin
            next_out_latch = data_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_latch <= bgdio_pkg::DATA_RESET;
        end else begin
            out_latch <= next_out_latch;
        end
    end

    // Drive and enable are registered together, so a line never shows new data
    // one cycle before its enable or the other way round.
    always_comb begin
        next_pin_oe  = expand(grp_out);
        next_pin_out = drive_value(out_latch, grp_out, fixed_mode, hold_strobe);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= bgdio_pkg::DATA_RESET;
            pin_oe  <= bgdio_pkg::DATA_RESET;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

    // Read-back samples the pins every cycle, so an input shows its level one edge later.
    always_comb begin
        next_rdata   = read_back(pin_in, out_latch, grp_out);
        next_dir_out = grp_out;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            data_rdata <= bgdio_pkg::DATA_RESET;
            dir_out    <= bgdio_pkg::DIR_RESET;
        end else begin
            data_rdata <= next_rdata;
            dir_out    <= next_dir_out;
        end
    end

    a_oe_group: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pin_oe[7:0] == 8'h00 || pin_oe[7:0] == 8'hff)
        && (pin_oe[15:8] == 8'h00 || pin_oe[15:8] == 8'hff))
        else $error("Output enables split inside a group.");

    a_in_reads: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rst_b && !grp_out[0] |=> data_rdata[7:0] == $past(pin_in[7:0]))
        else $error("Input group read back wrong level.");

    a_out_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
        data_wr && !direction_mode_jumper && $stable(direction_mode_jumper) && grp_out[0]
        ##1 grp_out[0] |=> pin_out[7:0] == $past(data_wdata[7:0], 2))
        else $error("Output line did not follow written data.");

    a_soft_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !direction_mode_jumper && cfg_wr && cfg_split == 2'h2 ##1 !direction_mode_jumper
        |=> dir_out == 2'h3)
        else $error("Software direction not applied.");

    a_fixed_split: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rst_b && direction_mode_jumper |=> pin_oe == 16'hff00
        && pin_out[15] == $past(hold_strobe))
        else $error("Fixed split or hold strobe wrong.");

    a_reset_in: assert property (@(posedge clk_sys)
        $rose(rst_b) && !direction_mode_jumper |=> pin_oe == 16'h0000)
        else $error("Lines not inputs after reset.");

    a_legal_split: assert property (@(posedge clk_sys) disable iff (!rst_b)
        dir_out != 2'h1)
        else $error("Illegal direction split.");

    a_no_drive_in: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !grp_out[1] |=> pin_oe[15:8] == 8'h00)
        else $error("Input group driven.");

    a_no_drive_lo: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !grp_out[0] |=> pin_oe[7:0] == 8'h00)
        else $error("Low input group driven.");

    a_refuse_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_wr && cfg_split == bgdio_pkg::SPLIT_BAD |=> $stable(split))
        else $error("Refused split code was taken.");

    a_all_in: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !direction_mode_jumper && cfg_wr && cfg_split == bgdio_pkg::SPLIT_ALL_IN
        ##1 !direction_mode_jumper |=> dir_out == 2'h0)
        else $error("Sixteen-input split not applied.");

    a_half_split: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !direction_mode_jumper && cfg_wr && cfg_split == bgdio_pkg::SPLIT_HALF
        ##1 !direction_mode_jumper |=> dir_out == 2'h2)
        else $error("Half split not applied.");

    a_fixed_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rst_b && direction_mode_jumper |=> dir_out == 2'h2)
        else $error("Fixed mode direction wrong.");

    a_hi_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
        data_wr && !direction_mode_jumper && grp_out[1]
        ##1 !direction_mode_jumper && grp_out[1] |=> pin_out[15:8] == $past(data_wdata[15:8], 2))
        else $error("Upper output lines did not follow written data.");

    a_hold_soft: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !direction_mode_jumper && grp_out[1]
        |=> pin_out[15] == $past(out_latch[15]))
        else $error("Hold strobe reached line 15 outside fixed mode.");

    a_dir_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pin_oe[0] == dir_out[0] && pin_oe[8] == dir_out[1])
        else $error("Enables disagree with group direction.");

    a_in_reads_hi: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rst_b && !grp_out[1] |=> data_rdata[15:8] == $past(pin_in[15:8]))
        else $error("Upper input group read back wrong level.");

    a_latch_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        data_wr |=> out_latch == $past(data_wdata))
        else $error("Written data not held in the latch.");

endmodule : bgdio_port
`default_nettype wire

// ---- testbench/bgdio_load_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bgdio_load_model (
    input  wire logic [15:0] sw_open,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    output logic      [15:0] pin_in
);
    // A released line sits at the switch: a closed switch pulls it to 0, the pull-up gives 1.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw_open);
endmodule : bgdio_load_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        jmp = 1'b0;
    logic        cfg_wr = 1'b0;
    logic        data_wr = 1'b0;
    logic        hold = 1'b0;
    logic        chk = 1'b0;
    logic [1:0]  cfg_split = 2'h0;
    logic [1:0]  split = 2'h0;
    logic [15:0] data_wdata = 16'h0000;
    logic [15:0] lat = 16'h0000;
    logic [15:0] sw = 16'hffff;
    logic [15:0] pin_in, pin_out, pin_oe, data_rdata;
    logic [1:0]  dir_out;
    logic [49:0] exp_q[$];
    logic [49:0] seen;
    int          error_cnt = 0;
    int          compares = 0;
    always #50 clk_sys = ~clk_sys;
    bgdio_port bgdio_port_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .direction_mode_jumper(jmp), .cfg_wr(cfg_wr), .cfg_split(cfg_split),
        .data_wr(data_wr), .data_wdata(data_wdata), .hold_strobe(hold), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .data_rdata(data_rdata), .dir_out(dir_out));
    bgdio_load_model bgdio_load_model_inst (.sw_open(sw), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));
    task automatic finish_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic check_eq(input logic [49:0] seen, input logic [49:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: port state %h expected %h", $time, seen, exp);
        end
    endtask : check_eq
    // Only driven lines are compared on pin_out; released lines carry no meaning.
    assign seen = {dir_out, pin_oe, pin_out & pin_oe, data_rdata};
    always @(negedge clk_sys) begin
        if (chk) begin
            check_eq(seen, exp_q.pop_front());
        end
    end
    task automatic run(input logic j, input logic wr, input logic [1:0] sp);
        logic [1:0]  dir;
        logic [15:0] oe;
        logic [15:0] po;
        if (wr) lat = 16'($urandom);
        @(posedge clk_sys);
        jmp <= j;
        cfg_wr <= wr;
        data_wr <= wr;
        cfg_split <= sp;
        data_wdata <= lat;
        sw <= 16'($urandom);
        hold <= 1'($urandom);
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        data_wr <= 1'b0;
        repeat (3) @(posedge clk_sys);
        if (wr && sp != 2'h3) split = sp;
        dir = j ? bgdio_pkg::DIR_FIXED : (split == 2'h0 ? 2'h0 : split == 2'h1 ? 2'h2 : 2'h3);
        oe = {{8{dir[1]}}, {8{dir[0]}}};
        po = lat;
        if (j) po[15] = hold;
        exp_q.push_back({dir, oe, po & oe, (oe & lat) | (~oe & sw)});
        chk <= 1'b1;
        @(posedge clk_sys);
        chk <= 1'b0;
    endtask : run
    initial begin
        #2000000;
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hbafa));
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        run(1'b0, 1'b0, 2'h0);
        for (int i = 0; i < 4; i++) run(1'b0, 1'b1, 2'(i));
        // A second reset while all lines drive must bring every line back to input.
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        split = bgdio_pkg::SPLIT_ALL_IN;
        lat = bgdio_pkg::DATA_RESET;
        run(1'b0, 1'b0, 2'h0);
        run(1'b1, 1'b1, 2'h0);
        run(1'b1, 1'b1, 2'h1);
        run(1'b0, 1'b0, 2'h0);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
